// file: tb/jtap_asserts.sv
`timescale 1ns/1ps
module jtap_asserts (
  // clock and reset
  input wire logic                       clk_in,
  input wire logic                       nrst_in,
  // watched pins and status
  input wire logic                       tck_in,
  input wire logic                       tms_in,
  input wire logic                       tdo_oe_out,
  input wire logic [jtap_pkg::BSR_W-1:0] bsr_par_out,
  input wire logic [jtap_pkg::IR_W-1:0]  instr_out,
  input wire logic [15:0]                state_out
);
  import jtap_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic       tck_q_reg;
  logic [2:0] hi_cnt_reg;
  // count tck rises seen with tms high, saturating at five
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tck_q_reg  <= 1'b0;
      hi_cnt_reg <= 3'h0;
    end else begin
      tck_q_reg <= tck_in;
      if (tck_in && !tck_q_reg) begin
        hi_cnt_reg <= !tms_in ? 3'h0 : ((hi_cnt_reg == 3'h5) ? 3'h5 : hi_cnt_reg + 3'h1);
      end
    end
  end
  // the state register has just left the given state
  sequence s_leave(logic [15:0] from);
    $past(state_out) == from && state_out != from;
  endsequence
  // the state moved one clock back; the tms it used was sampled two clocks before that
  property p_next(logic [15:0] from, logic [15:0] hi, logic [15:0] lo);
    s_leave(from) |-> state_out == ($past(tms_in, 3) ? hi : lo);
  endproperty
  // successor of reset, idle, dr select, dr capture and each update state
  AST_RESET: assert property (p_next(ST_RESET, ST_RESET, ST_IDLE))
    else $error("bad successor");
  AST_IDLE: assert property (p_next(ST_IDLE, ST_SELDR, ST_IDLE))
    else $error("bad successor");
  AST_SELDR: assert property (p_next(ST_SELDR, ST_SELIR, ST_CAPDR))
    else $error("bad successor");
  AST_CAPDR: assert property (p_next(ST_CAPDR, ST_EX1DR, ST_SHDR))
    else $error("bad successor");
  AST_UPDR: assert property (p_next(ST_UPDR, ST_SELDR, ST_IDLE))
    else $error("bad successor");
  AST_UPIR: assert property (p_next(ST_UPIR, ST_SELDR, ST_IDLE))
    else $error("bad successor");
  // five high rises land in reset within the synchroniser delay
  AST_FIVE_HIGH: assert property (hi_cnt_reg == 3'h5 |-> ##[0:4] state_out == ST_RESET)
    else $error("five tms-high rises did not reach reset");
  // successor of each scan state and of the ir select and capture states
  AST_SHDR: assert property (p_next(ST_SHDR, ST_EX1DR, ST_SHDR))
    else $error("bad successor");
  AST_EX1DR: assert property (p_next(ST_EX1DR, ST_UPDR, ST_PSDR))
    else $error("bad successor");
  AST_PSDR: assert property (p_next(ST_PSDR, ST_EX2DR, ST_PSDR))
    else $error("bad successor");
  AST_EX2DR: assert property (p_next(ST_EX2DR, ST_UPDR, ST_SHDR))
    else $error("bad successor");
  AST_SELIR: assert property (p_next(ST_SELIR, ST_RESET, ST_CAPIR))
    else $error("bad successor");
  AST_CAPIR: assert property (p_next(ST_CAPIR, ST_EX1IR, ST_SHIR))
    else $error("bad successor");
  AST_SHIR: assert property (p_next(ST_SHIR, ST_EX1IR, ST_SHIR))
    else $error("bad successor");
  AST_EX1IR: assert property (p_next(ST_EX1IR, ST_UPIR, ST_PSIR))
    else $error("bad successor");
  AST_PSIR: assert property (p_next(ST_PSIR, ST_EX2IR, ST_PSIR))
    else $error("bad successor");
  AST_EX2IR: assert property (p_next(ST_EX2IR, ST_UPIR, ST_SHIR))
    else $error("bad successor");
  // latched outputs move only in their update states, the instruction also in reset
  AST_BSR_HOLD: assert property ($changed(bsr_par_out) |-> state_out == ST_UPDR)
    else $error("parallel output moved outside update");
  AST_INSTR_HOLD: assert property ($changed(instr_out) |-> state_out inside {ST_UPIR, ST_RESET})
    else $error("instruction moved outside update");
  AST_OE_SHIFT: assert property ($rose(tdo_oe_out) |-> state_out inside {ST_SHDR, ST_SHIR})
    else $error("tdo enabled outside shift");
endmodule
bind jtap_top jtap_asserts i_asserts (
  .clk_in(clk_in), .nrst_in(nrst_in), .tck_in(tck_in), .tms_in(tms_in), .tdo_oe_out(tdo_oe_out),
  .bsr_par_out(bsr_par_out), .instr_out(instr_out), .state_out(state_out)
);

// file: tb/jtap_tester.sv
`timescale 1ns/1ps
module jtap_tester (
  // clock
  input  wire logic clk_in,
  // test port pins
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  // tck parked low between frames, tdi at its pull-up level
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // one 320 ns tck period; tdo taken just before the fall
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge clk_in);
    tms_out = m;
    tdi_out = d;
    repeat (3) @(negedge clk_in);
    tck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    o = tdo_oe_in ? tdo_in : ~tdo_in; // a released tdo shows a wrong bit
    tck_out = 1'b0;
  endtask
  task automatic reset5();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
  endtask
endmodule

// file: tb/jtap_top_tb.sv
`timescale 1ns/1ps
module jtap_top_tb;
  import jtap_pkg::*;
  logic              clk_in, nrst_in, tck, tms, tdi, tdo_out, tdo_oe_out, test_mode_out;
  logic              strm_valid_out, strm_ready_in;
  logic [BSR_W-1:0]  pin_in, bsr_par_out, par;
  logic [IR_W-1:0]   instr_out, cur;
  logic [15:0]       state_out;
  logic [FIFO_W-1:0] strm_data_out;
  int                mismatches, checked, cycles;

  // design and far-side tester
  jtap_top i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pin_in(pin_in), .bsr_par_out(bsr_par_out),
    .instr_out(instr_out), .state_out(state_out), .test_mode_out(test_mode_out),
    .strm_valid_out(strm_valid_out), .strm_ready_in(strm_ready_in),
    .strm_data_out(strm_data_out)
  );
  jtap_tester i_tester (.clk_in(clk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));

  // clock and hang ceiling
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one tck period, then the new state is compared
  task automatic walk(input logic m, input logic d, input logic [15:0] exp, output logic o);
    i_tester.step(m, d, o);
    check(state_out, exp);
  endtask
  task automatic t_reset();
    logic o;
    check(state_out, ST_RESET);
    check(instr_out, IR_IDCODE);
    walk(1'b0, 1'b1, ST_IDLE, o);
    walk(1'b0, 1'b1, ST_IDLE, o);
    walk(1'b1, 1'b1, ST_SELDR, o);
    walk(1'b1, 1'b1, ST_SELIR, o);
    walk(1'b1, 1'b1, ST_RESET, o);
    walk(1'b1, 1'b1, ST_RESET, o);
    walk(1'b0, 1'b1, ST_IDLE, o);
    walk(1'b1, 1'b1, ST_SELDR, o);
    walk(1'b0, 1'b1, ST_CAPDR, o);
    walk(1'b1, 1'b1, ST_EX1DR, o);
    walk(1'b0, 1'b1, ST_PSDR, o);
    i_tester.reset5();
    check(state_out, ST_RESET);
    $display("test reset done");
  endtask
  // instruction load with a pause before the last bit
  task automatic load_ir(input logic [IR_W-1:0] code);
    logic o;
    walk(1'b0, 1'b1, ST_IDLE, o);
    walk(1'b1, 1'b1, ST_SELDR, o);
    walk(1'b1, 1'b1, ST_SELIR, o);
    walk(1'b0, 1'b1, ST_CAPIR, o);
    walk(1'b0, 1'b1, ST_SHIR, o);
    walk(1'b0, code[0], ST_SHIR, o);
    check(o, 1'b0);
    walk(1'b1, code[1], ST_EX1IR, o);
    check(o, 1'b0);
    walk(1'b0, 1'b1, ST_PSIR, o);
    walk(1'b0, 1'b1, ST_PSIR, o);
    walk(1'b1, 1'b1, ST_EX2IR, o);
    check(instr_out, cur);
    walk(1'b0, 1'b1, ST_SHIR, o);
    walk(1'b1, code[2], ST_EX1IR, o);
    check(o, 1'b1);
    walk(1'b1, 1'b1, ST_UPIR, o);
    repeat (6) @(negedge clk_in);
    check(instr_out, code);
    check(test_mode_out, code == IR_EXTEST);
    cur = code;
  endtask
  // boundary scan: captured pins out, new word latched at update
  task automatic scan_dr(input logic [7:0] din, input logic [7:0] pins);
    logic o;
    pin_in = pins;
    walk(1'b0, 1'b1, ST_IDLE, o);
    walk(1'b1, 1'b1, ST_SELDR, o);
    walk(1'b0, 1'b1, ST_CAPDR, o);
    walk(1'b0, 1'b1, ST_SHDR, o);
    for (int i = 0; i < 8; i++) begin
      walk(i == 7, din[i], (i == 7) ? ST_EX1DR : ST_SHDR, o);
      check(o, pins[i]);
      check(bsr_par_out, par);
    end
    walk(1'b0, 1'b1, ST_PSDR, o);
    walk(1'b0, 1'b1, ST_PSDR, o);
    walk(1'b1, 1'b1, ST_EX2DR, o);
    walk(1'b1, 1'b1, ST_UPDR, o);
    check(bsr_par_out, par);
    repeat (6) @(negedge clk_in);
    check(bsr_par_out, din);
    par = din;
  endtask
  // ten bytes: one held at the output stage, eight buffered, the last dropped
  task automatic t_stream();
    strm_ready_in = 1'b0;
    for (int k = 0; k < 10; k++) scan_dr(8'(k + 16), 8'(k));
    for (int k = 0; k < 9; k++) begin
      @(negedge clk_in);
      check(strm_valid_out, 1'b1);
      check(strm_data_out, 8'(k));
      strm_ready_in = 1'b1;
      @(negedge clk_in);
      strm_ready_in = 1'b0;
    end
    @(negedge clk_in);
    check(strm_valid_out, 1'b0);
    strm_ready_in = 1'b1;
    $display("test stream done");
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    nrst_in = 1'b0;
    pin_in = 8'h00;
    par = 8'h00;
    cur = IR_IDCODE;
    strm_ready_in = 1'b1;
    repeat (6) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_reset();
    load_ir(IR_EXTEST);
    load_ir(IR_IDCODE);
    load_ir(IR_BYPASS);
    load_ir(IR_SAMPLE);
    $display("test instruction done");
    scan_dr(8'h3C, 8'hA5);
    $display("test boundary done");
    t_stream();
    results();
  end
endmodule

// file: verilog/jtap_fifo.sv
`timescale 1ns/1ps
module jtap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // handshake terms
  assign wr_ready_out = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out  = mem_reg[rd_ptr_reg];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// file: verilog/jtap_pkg.sv
package jtap_pkg;
  localparam int IR_W  = 3;
  localparam int BSR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h4;
  localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h1;
  localparam logic [IR_W-1:0] IR_IDCODE  = 3'h2;
  localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
  // identification word: arbitrary value
  localparam logic [31:0] ID_WORD = 32'h1234_5671;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 8;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020, ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR  = 16'h8000
  } jtap_state_e;
endpackage

// file: verilog/jtap_top.sv
`timescale 1ns/1ps
module jtap_top (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  // test port pins
  input  wire logic                       tck_in,
  input  wire logic                       tms_in,
  input  wire logic                       tdi_in,
  output logic                            tdo_out,
  output logic                            tdo_oe_out,
  // boundary pins
  input  wire logic [jtap_pkg::BSR_W-1:0] pin_in,
  output logic      [jtap_pkg::BSR_W-1:0] bsr_par_out,
  // status
  output logic      [jtap_pkg::IR_W-1:0]  instr_out,
  output logic      [15:0]                state_out,
  output logic                            test_mode_out,
  // shifted-out byte stream
  output logic                            strm_valid_out,
  input  wire logic                       strm_ready_in,
  output logic      [jtap_pkg::FIFO_W-1:0] strm_data_out
);
  import jtap_pkg::*;

  logic              rst_s1_reg;
  logic              rst_n;
  logic [2:0]        tck_s_reg;
  logic [1:0]        tms_s_reg;
  logic [1:0]        tdi_s_reg;
  logic [1:0]        pin_s1_reg [BSR_W];
  logic [BSR_W-1:0]  pin_sync;
  logic              tck_rise;
  logic              tck_fall;
  logic              tms_s;
  logic              tdi_s;
  jtap_state_e       state_reg;
  jtap_state_e       state_next;
  logic [IR_W-1:0]   ir_sh_reg;
  logic [IR_W-1:0]   ir_reg;
  logic [BSR_W-1:0]  bsr_sh_reg;
  logic [BSR_W-1:0]  bsr_par_reg;
  logic [31:0]       id_sh_reg;
  logic              byp_reg;
  logic              tdo_reg;
  logic              tdo_oe_reg;
  logic              test_mode_reg;
  logic              bsr_sel;
  logic              id_sel;
  logic [FIFO_W-1:0] col_reg;
  logic [2:0]        col_cnt_reg;
  logic              col_push;
  logic              fifo_ready;
  logic              strm_valid;
  logic [FIFO_W-1:0] strm_data;
  logic              strm_valid_reg;
  logic [FIFO_W-1:0] strm_data_reg;
  logic              fifo_pop;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // pin synchronisers; tck keeps a third stage for edge finding
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tck_s_reg <= 3'h0;
      tms_s_reg <= 2'h3;
      tdi_s_reg <= 2'h0;
    end else begin
      tck_s_reg <= {tck_s_reg[1:0], tck_in};
      tms_s_reg <= {tms_s_reg[0], tms_in};
      tdi_s_reg <= {tdi_s_reg[0], tdi_in};
    end
  end

  // boundary pin synchronisers, one per bit
  for (genvar i = 0; i < BSR_W; i++) begin : g_pin
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_reg[i] <= 2'h0;
      end else begin
        pin_s1_reg[i] <= {pin_s1_reg[i][0], pin_in[i]};
      end
    end
    assign pin_sync[i] = pin_s1_reg[i][1];
  end

  assign tck_rise = tck_s_reg[1] && !tck_s_reg[2];
  assign tck_fall = !tck_s_reg[1] && tck_s_reg[2];
  assign tms_s    = tms_s_reg[1];
  assign tdi_s    = tdi_s_reg[1];
  assign bsr_sel  = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLE);
  assign id_sel   = (ir_reg == IR_IDCODE);

  // next-state decode on tms
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE:  state_next = tms_s ? ST_SELDR : ST_IDLE;
      ST_SELDR: state_next = tms_s ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_next = tms_s ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  state_next = tms_s ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_next = tms_s ? ST_UPDR : ST_PSDR;
      ST_PSDR:  state_next = tms_s ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: state_next = tms_s ? ST_UPDR : ST_SHDR;
      ST_UPDR:  state_next = tms_s ? ST_SELDR : ST_IDLE;
      ST_SELIR: state_next = tms_s ? ST_RESET : ST_CAPIR;
      ST_CAPIR: state_next = tms_s ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  state_next = tms_s ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_next = tms_s ? ST_UPIR : ST_PSIR;
      ST_PSIR:  state_next = tms_s ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: state_next = tms_s ? ST_UPIR : ST_SHIR;
      ST_UPIR:  state_next = tms_s ? ST_SELDR : ST_IDLE;
      default:  state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // instruction shift stage
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_reg <= IR_CAPTURE;
    end else if (tck_rise) begin
      if (state_reg == ST_CAPIR) begin
        ir_sh_reg <= IR_CAPTURE;
      end else if (state_reg == ST_SHIR) begin
        ir_sh_reg <= {tdi_s, ir_sh_reg[IR_W-1:1]};
      end
    end
  end

  // current instruction, reloaded in test-logic-reset
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg <= IR_IDCODE;
    end else if (state_reg == ST_RESET) begin
      ir_reg <= IR_IDCODE;
    end else if (tck_fall && state_reg == ST_UPIR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  // extest flag kept in step with the current instruction, so the pin stays glitch-free
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      test_mode_reg <= 1'b0;
    end else if (state_reg == ST_RESET) begin
      test_mode_reg <= 1'b0; // reset instruction is never extest
    end else if (tck_fall && state_reg == ST_UPIR) begin
      test_mode_reg <= (ir_sh_reg == IR_EXTEST);
    end
  end

  // data registers: boundary, id and bypass
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bsr_sh_reg <= '0;
      id_sh_reg  <= ID_WORD;
      byp_reg    <= 1'b0;
    end else if (tck_rise) begin
      if (state_reg == ST_CAPDR) begin
        if (bsr_sel) begin
          bsr_sh_reg <= pin_sync;
        end
        if (id_sel) begin
          id_sh_reg <= ID_WORD;
        end
        byp_reg <= 1'b0;
      end else if (state_reg == ST_SHDR) begin
        if (bsr_sel) begin
          bsr_sh_reg <= {tdi_s, bsr_sh_reg[BSR_W-1:1]};
        end else if (id_sel) begin
          id_sh_reg <= {tdi_s, id_sh_reg[31:1]};
        end else begin
          byp_reg <= tdi_s;
        end
      end
    end
  end

  // boundary parallel output
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bsr_par_reg <= '0;
    end else if (tck_fall && state_reg == ST_UPDR && bsr_sel) begin
      bsr_par_reg <= bsr_sh_reg;
    end
  end

  // tdo changes on falling tck, driven only while shifting
  // the tester samples just before the next fall, so a tck period less the synchroniser delay is left for settling
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_reg <= (state_reg == ST_SHDR) || (state_reg == ST_SHIR);
      if (state_reg == ST_SHIR) begin
        tdo_reg <= ir_sh_reg[0];
      end else if (bsr_sel) begin
        tdo_reg <= bsr_sh_reg[0];
      end else if (id_sel) begin
        tdo_reg <= id_sh_reg[0];
      end else begin
        tdo_reg <= byp_reg;
      end
    end
  end

  // collect bits leaving the data register into bytes
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      col_reg     <= '0;
      col_cnt_reg <= 3'h0;
    end else if (tck_rise && state_reg == ST_SHDR) begin
      col_reg     <= {tdo_reg, col_reg[FIFO_W-1:1]};
      col_cnt_reg <= col_cnt_reg + 3'h1;
    end
  end

  // a byte is offered when the eighth bit lands; dropped if full
  assign col_push = tck_rise && (state_reg == ST_SHDR) && (col_cnt_reg == 3'h7) && fifo_ready;

  jtap_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n),
    .wr_valid_in  (col_push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   ({tdo_reg, col_reg[FIFO_W-1:1]}),
    .rd_valid_out (strm_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (strm_data)
  );

  // output stage registers the fifo head
  // it refills in the cycle it is drained, so it holds one byte beyond the fifo
  assign fifo_pop = strm_valid && (!strm_valid_reg || strm_ready_in);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      strm_valid_reg <= 1'b0;
      strm_data_reg  <= '0;
    end else if (fifo_pop) begin
      strm_valid_reg <= 1'b1;
      strm_data_reg  <= strm_data;
    end else if (strm_ready_in) begin
      strm_valid_reg <= 1'b0;
    end
  end

  // registered outputs
  assign tdo_out        = tdo_reg;
  assign tdo_oe_out     = tdo_oe_reg;
  assign bsr_par_out    = bsr_par_reg;
  assign instr_out      = ir_reg;
  assign state_out      = state_reg;
  assign test_mode_out  = test_mode_reg;
  assign strm_valid_out = strm_valid_reg;
  assign strm_data_out  = strm_data_reg;
endmodule
